//--- design/wdt_pkg.sv
/*
 * Constants shared by the watchdog interval timer: register offsets, field
 * positions, reset values, pair codes and prescaler divide counts.
 * Assumes an 8-bit register port with an 8-bit address.
 */
// =====================================================================
// Package
package wdt_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // =================================================================
    // Register offsets.
    localparam logic [7:0] CTRL_OFS = 8'hA1;
    localparam logic [7:0] COUNT_OFS = 8'hA2;
    localparam logic [7:0] STAT_OFS = 8'hA8;
    localparam logic [7:0] MASK_OFS = 8'hA9;
    // =================================================================
    // Control field positions.
    localparam int RUN_HI = 7;
    localparam int RUN_LO = 6;
    localparam int REN_HI = 5;
    localparam int REN_LO = 4;
    localparam int CAUSE_BIT = 3;
    localparam int SEL_HI = 1;
    localparam int SEL_LO = 0;
    localparam int UF_BIT = 0;
    // =================================================================
    // Reset values and codes.
    localparam logic [1:0] PAIR_OFF = 2'h1;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [7:0] COUNT_RST = 8'hFF;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    // =================================================================
    // Prescaler divide counts, one per select code.
    localparam int DIV_SYS = 12;
    localparam int DIV_F1 = 32;
    localparam int DIV_F2 = 1024;
    localparam int DIV_F3 = 16384;
    localparam int PRE_W = 14;
    // Length of the chip reset pulse after an enabled underflow.
    localparam int RST_PULSE_CYC = 4;
endpackage

//--- design/wdt_tick_gen.sv
/*
 * Prescaler that turns the clock into the selected counting tick.
 * Assumes select and run come from registers on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module wdt_tick_gen #(
    parameter int DIV0 = wdt_pkg::DIV_SYS,
    parameter int DIV1 = wdt_pkg::DIV_F1,
    parameter int DIV2 = wdt_pkg::DIV_F2,
    parameter int DIV3 = wdt_pkg::DIV_F3
) (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Control.
    input wire logic clr_in,
    input wire logic run_in,
    input wire logic [1:0] sel_in,
    // Tick.
    output logic tick_out
);
    // =================================================================
    // Divider
    localparam int PW = wdt_pkg::PRE_W;

    function automatic logic [PW-1:0] last_of(input logic [1:0] s);
        case (s)
            2'h0: last_of = PW'(DIV0 - 1);
            2'h1: last_of = PW'(DIV1 - 1);
            2'h2: last_of = PW'(DIV2 - 1);
            default: last_of = PW'(DIV3 - 1);
        endcase
    endfunction

    logic [wdt_pkg::PRE_W-1:0] cnt_q;
    logic [1:0] sel_q;
    logic wrap;

    assign wrap = (cnt_q >= last_of(sel_in));
    // No tick in the cycle a select change restarts the count.
    assign tick_out = run_in && wrap && sel_q == sel_in;

    // The count freezes while stopped; a select change restarts it so the
    // new period is never cut short by a stale count.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_q <= '0;
            sel_q <= wdt_pkg::SEL_RST;
        end else begin
            sel_q <= sel_in;
            if (clr_in || sel_q != sel_in) begin
                cnt_q <= '0;
            end else if (run_in) begin
                cnt_q <= wrap ? '0 : cnt_q + 1'b1;
            end
        end
    end

    chk_tick_period: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        tick_out |-> cnt_q == last_of(sel_in))
        else $error("tick away from the selected divide");
    chk_tick_stopped: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !run_in |-> !tick_out)
        else $error("tick while stopped");
endmodule
`default_nettype wire

//--- design/wdt_reset_ctrl.sv
/*
 * Chip reset pulse and reset-cause flag for the watchdog.
 * Assumes the pin reset arrives on sys_rst_in, already synchronous to the clock
 * in its release.
 */
`timescale 1ns/1ps
`default_nettype none
module wdt_reset_ctrl #(
    parameter int PULSE = wdt_pkg::RST_PULSE_CYC
) (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Trigger.
    input wire logic start_in,
    // Results.
    output logic pulse_out,
    output logic cause_out
);
    // =================================================================
    // Pulse stretcher
    localparam int CW = $clog2(PULSE + 1);
    logic [CW-1:0] cnt_q;

    // The pulse begins the cycle after the underflow and lasts PULSE cycles.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_q <= '0;
            pulse_out <= 1'b0;
        end else begin
            if (start_in) begin
                cnt_q <= CW'(PULSE);
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end
            pulse_out <= start_in || cnt_q > CW'(1);
        end
    end

    // Only the pin reset clears the cause; the watchdog's own reset sets it.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cause_out <= 1'b0;
        end else if (start_in) begin
            cause_out <= 1'b1;
        end
    end

    chk_pulse_start: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        start_in |=> pulse_out && cause_out)
        else $error("no reset pulse after enabled underflow");
    chk_cause_sticky: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        cause_out |=> cause_out)
        else $error("reset cause cleared without pin reset");
endmodule
`default_nettype wire

//--- design/watchdog_interval_timer.sv
/*
 * Watchdog interval timer: 8-bit down-counter with prescaled clock select,
 * redundant run and reset-enable pairs, reset cause, interrupt flag.
 * Assumes a single-cycle strobe register port on ref_clk_in, sys_rst_in as
 * the pin reset, and an interrupt controller that pulses int_ack_in on entry.
 */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Reset-cause bit 3 reads 0 after pin reset, 1 after watchdog reset; read only.
// - Clock select 00 sys/12, 01 fast/32, 10 fast/1024, 11 fast/16384.
// - Count register is 8-bit down-counter, FFh after reset, read and write.
// - Writing the count loads it, even while counting, without stopping.
// - Time to underflow is period times (count+1) minus under one period.
// - Run pair 10 counts; writing 01 freezes counter at its value.
// - Reset pair 10 resets chip on underflow; 01 makes a plain interval timer.
// - Enabled underflow resets chip, reinitialises registers, records watchdog cause.
// - Every underflow sets the interrupt flag, reset enabled or not.
// - Interrupt service entry clears the flag by hardware.
// - Writing FFh at count 00h may underflow; other writes never do.
// - Run pair 00 and 11 count like 10; only 01 stops.
// - Reset pair 00 and 11 enable reset like 10; only 01 disables.
module watchdog_interval_timer #(
    parameter int DIV0 = wdt_pkg::DIV_SYS,
    parameter int DIV1 = wdt_pkg::DIV_F1,
    parameter int DIV2 = wdt_pkg::DIV_F2,
    parameter int DIV3 = wdt_pkg::DIV_F3,
    parameter int PULSE = wdt_pkg::RST_PULSE_CYC
) (
    // Clock and pin reset.
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Register port.
    input wire logic [7:0] bus_addr_in,
    input wire logic [7:0] bus_wdata_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    output logic [7:0] bus_rdata_out,
    // Interrupt controller.
    input wire logic int_ack_in,
    output logic underflow_interrupt_flag_out,
    output logic irq_out,
    // Chip reset.
    output logic chip_reset_out,
    output logic reset_cause_flag_out
);
    // =================================================================
    // Decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // Only the code 01 means off, so one upset bit cannot disable a pair set to 10.
    function automatic logic pair_on(input logic [1:0] p);
        pair_on = (p != wdt_pkg::PAIR_OFF);
    endfunction

    // Decoded strobes and internal levels.
    logic wr_ctrl;
    logic wr_cnt;
    logic wr_stat;
    logic wr_mask;
    logic soft_rst;
    logic run;
    logic rst_en;
    logic tick;
    logic underflow;
    logic start_rst;

    // One write strobe per mapped offset.
    assign wr_ctrl = bus_wr_in && hit(bus_addr_in, wdt_pkg::CTRL_OFS);
    assign wr_cnt = bus_wr_in && hit(bus_addr_in, wdt_pkg::COUNT_OFS);
    assign wr_stat = bus_wr_in && hit(bus_addr_in, wdt_pkg::STAT_OFS);
    assign wr_mask = bus_wr_in && hit(bus_addr_in, wdt_pkg::MASK_OFS);

    // =================================================================
    // Control register
    // Control fields; the cause bit lives in the reset control.
    logic [1:0] run_control_pair_q;
    logic [1:0] reset_enable_pair_q;
    logic [1:0] count_clock_select_q;

    // The watchdog reset pulse reinitialises the control, count, flag and mask registers and the prescaler count.
    assign soft_rst = chip_reset_out;

    // Bit 3 and bit 2 are not writable; the cause lives in the reset control.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            run_control_pair_q <= wdt_pkg::PAIR_OFF;
            reset_enable_pair_q <= wdt_pkg::PAIR_OFF;
            count_clock_select_q <= wdt_pkg::SEL_RST;
        end else if (soft_rst) begin
            run_control_pair_q <= wdt_pkg::PAIR_OFF;
            reset_enable_pair_q <= wdt_pkg::PAIR_OFF;
            count_clock_select_q <= wdt_pkg::SEL_RST;
        end else if (wr_ctrl) begin
            run_control_pair_q <= bus_wdata_in[wdt_pkg::RUN_HI:wdt_pkg::RUN_LO];
            reset_enable_pair_q <= bus_wdata_in[wdt_pkg::REN_HI:wdt_pkg::REN_LO];
            count_clock_select_q <= bus_wdata_in[wdt_pkg::SEL_HI:wdt_pkg::SEL_LO];
        end
    end

    // Pair levels; the watchdog pulse also halts counting.
    assign run = pair_on(run_control_pair_q) && !soft_rst;
    assign rst_en = pair_on(reset_enable_pair_q);

    // =================================================================
    // Prescaler
    // The prescaler is not restarted by a count load, so the first period
    // after a load is short by less than one tick.
    wdt_tick_gen #(
        .DIV0(DIV0),
        .DIV1(DIV1),
        .DIV2(DIV2),
        .DIV3(DIV3)
    ) u_tick (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .clr_in(soft_rst),
        .run_in(run),
        .sel_in(count_clock_select_q),
        .tick_out(tick)
    );

    // =================================================================
    // Down-counter
    // The count, readable and writable at its offset.
    logic [7:0] count_q;

    // A tick at 00h underflows; a load in the same cycle takes over the
    // count, and only a load of FFh lets that underflow through.
    assign underflow = tick && count_q == wdt_pkg::COUNT_ZERO
        && (!wr_cnt || bus_wdata_in == wdt_pkg::COUNT_RST);

    // A load has priority over the tick but never stops the prescaler.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            count_q <= wdt_pkg::COUNT_RST;
        end else if (soft_rst) begin
            count_q <= wdt_pkg::COUNT_RST;
        end else if (wr_cnt) begin
            count_q <= bus_wdata_in;
        end else if (tick) begin
            count_q <= count_q - 8'h01;
        end
    end

    // =================================================================
    // Reset generation
    // Software must reload the count in time nothing here helps it.
    assign start_rst = underflow && rst_en && !soft_rst;

    wdt_reset_ctrl #(
        .PULSE(PULSE)
    ) u_rst (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(start_rst),
        .pulse_out(chip_reset_out),
        .cause_out(reset_cause_flag_out)
    );

    // =================================================================
    // Interrupt flag and mask
    // Sticky flag and its mask.
    logic flag_q;
    logic mask_q;

    // Set beats both the service-entry clear and the write-one clear, so an
    // underflow in the clearing cycle is never lost.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            flag_q <= 1'b0;
        end else if (underflow) begin
            flag_q <= 1'b1;
        end else if (soft_rst) begin
            flag_q <= 1'b0;
        end else if (int_ack_in || (wr_stat && bus_wdata_in[wdt_pkg::UF_BIT])) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mask_q <= 1'b0;
        end else if (soft_rst) begin
            mask_q <= 1'b0;
        end else if (wr_mask) begin
            mask_q <= bus_wdata_in[wdt_pkg::UF_BIT];
        end
    end

    // The mask gates only the line; the flag still sets while masked,
    // so software can poll it with the interrupt off.
    assign underflow_interrupt_flag_out = flag_q;
    assign irq_out = flag_q && mask_q;

    // =================================================================
    // Read port
    logic [7:0] rd_d;

    // Unmapped offsets and reserved bits read as zero.
    always_comb begin
        rd_d = 8'h00;
        if (hit(bus_addr_in, wdt_pkg::CTRL_OFS)) begin
            rd_d[wdt_pkg::RUN_HI:wdt_pkg::RUN_LO] = run_control_pair_q;
            rd_d[wdt_pkg::REN_HI:wdt_pkg::REN_LO] = reset_enable_pair_q;
            rd_d[wdt_pkg::CAUSE_BIT] = reset_cause_flag_out;
            rd_d[wdt_pkg::SEL_HI:wdt_pkg::SEL_LO] = count_clock_select_q;
        end else if (hit(bus_addr_in, wdt_pkg::COUNT_OFS)) begin
            rd_d = count_q;
        end else if (hit(bus_addr_in, wdt_pkg::STAT_OFS)) begin
            rd_d[wdt_pkg::UF_BIT] = flag_q;
        end else if (hit(bus_addr_in, wdt_pkg::MASK_OFS)) begin
            rd_d[wdt_pkg::UF_BIT] = mask_q;
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bus_rdata_out <= 8'h00;
        end else begin
            bus_rdata_out <= bus_rd_in ? rd_d : 8'h00;
        end
    end

    // =================================================================
    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    // A pin reset aborts every attempt; the watchdog pulse does not, so
    // checks that must not see it exclude soft_rst themselves.

    // Control writes leave the cause alone.
    chk_cause_read_only: assert property (
        wr_ctrl && !start_rst |=> $stable(reset_cause_flag_out))
        else $error("control write changed the reset cause");

    // The pulse restores the count.
    chk_count_reinit: assert property (
        soft_rst |=> count_q == 8'hFF)
        else $error("count not FFh after watchdog reset");

    // A load lands whole.
    chk_load_value: assert property (
        wr_cnt && !soft_rst |=> count_q == $past(bus_wdata_in))
        else $error("count load lost");

    // Pair 01 freezes the count.
    chk_stop_freezes: assert property (
        run_control_pair_q == 2'h1 && !wr_cnt && !soft_rst |=> $stable(count_q))
        else $error("count moved while stopped");

    // Each tick takes one off.
    chk_run_decrements: assert property (
        tick && !wr_cnt && count_q != 8'h00 |=> count_q == $past(count_q) - 8'h01)
        else $error("tick did not decrement");

    // Leaving 00h wraps to FFh.
    chk_underflow_wrap: assert property (
        underflow |=> count_q == 8'hFF)
        else $error("no wrap to FFh after underflow");

    // An enabled underflow starts the pulse.
    chk_reset_on_uf: assert property (
        underflow && rst_en && !soft_rst |=> chip_reset_out ##1 chip_reset_out)
        else $error("enabled underflow gave no reset");

    // Pair 01 never resets.
    chk_no_reset_off: assert property (
        underflow && reset_enable_pair_q == 2'h1 && !chip_reset_out |=> !chip_reset_out)
        else $error("reset with reset pair at 01");

    // Every underflow sets the flag.
    chk_flag_set: assert property (
        underflow |=> flag_q)
        else $error("underflow did not set the flag");

    // Service entry clears the flag.
    chk_ack_clears: assert property (
        int_ack_in && !underflow |=> !flag_q)
        else $error("service entry left the flag set");

    // Only an FFh load may pass an underflow.
    chk_write_no_uf: assert property (
        wr_cnt && bus_wdata_in != 8'hFF |-> !underflow)
        else $error("non-FFh write produced underflow");

    // Read data carry the count seen at the strobe.
    chk_rdata_count: assert property (
        bus_rd_in && hit(bus_addr_in, wdt_pkg::COUNT_OFS) |=> bus_rdata_out == $past(count_q))
        else $error("count read back wrong");

    // Read data stand one cycle, then zero.
    chk_rdata_idle: assert property (
        !bus_rd_in |=> bus_rdata_out == 8'h00)
        else $error("read data outlived the strobe");

    // The cause bit reads through the control offset.
    chk_rdata_cause: assert property (
        bus_rd_in && hit(bus_addr_in, wdt_pkg::CTRL_OFS)
        |=> bus_rdata_out[wdt_pkg::CAUSE_BIT] == $past(reset_cause_flag_out))
        else $error("cause bit read back wrong");

    // A control write sets the run pair.
    chk_ctrl_load: assert property (
        wr_ctrl && !soft_rst
        |=> run_control_pair_q == $past(bus_wdata_in[wdt_pkg::RUN_HI:wdt_pkg::RUN_LO]))
        else $error("run pair write lost");

    // Pair 01 lets no tick through.
    chk_stop_no_tick: assert property (
        run_control_pair_q == wdt_pkg::PAIR_OFF |-> !tick)
        else $error("tick with run pair at 01");

    // A reload never stops the timer.
    chk_load_keeps_run: assert property (
        wr_cnt && run && !start_rst |=> run)
        else $error("count load stopped the timer");

    // The pulse restores control and mask.
    chk_pulse_reinit: assert property (
        soft_rst |=> run_control_pair_q == wdt_pkg::PAIR_OFF
        && reset_enable_pair_q == wdt_pkg::PAIR_OFF && !mask_q)
        else $error("registers not reinitialised by watchdog reset");

    // The pulse clears the flag.
    chk_pulse_flag: assert property (
        soft_rst |=> !flag_q)
        else $error("flag survived watchdog reset");

    // No pulse without an enabled underflow.
    chk_no_reset_idle: assert property (
        !start_rst && !chip_reset_out |=> !chip_reset_out)
        else $error("reset pulse without underflow");

    // Writing one clears the flag.
    chk_w1c_clears: assert property (
        wr_stat && bus_wdata_in[wdt_pkg::UF_BIT] && !underflow |=> !flag_q)
        else $error("write-one left the flag set");

    cov_timer_uf: cover property (underflow && !rst_en);
    cov_wdt_reset: cover property (start_rst ##1 chip_reset_out);
    cov_load_running: cover property (wr_cnt && tick);
    cov_ack_race: cover property (underflow && int_ack_in);
endmodule
`default_nettype wire

//--- testbench/testbench.sv
/*
 * Self-checking bench for the watchdog interval timer: register access,
 * clock select timing, run and reset-enable pairs, interrupt flag and reset.
 * Assumes the design files and package are compiled first; the bench drives
 * every port itself with the one-cycle strobe register protocol.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // =================================================================
    // Signals and small divide counts so that every interval stays short.
    localparam int DIV_TAB [4] = '{3, 4, 8, 16};
    localparam int PULSE = 4;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] bus_addr_in = 8'h00;
    logic [7:0] bus_wdata_in = 8'h00;
    logic bus_wr_in = 1'b0;
    logic bus_rd_in = 1'b0;
    logic int_ack_in = 1'b0;
    logic [7:0] bus_rdata_out;
    logic flag;
    logic irq;
    logic chip_rst;
    logic cause;
    int failures = 0;
    int num_checks = 0;
    logic [7:0] v;
    int cyc;
    int d;

    watchdog_interval_timer #(.DIV0(3), .DIV1(4), .DIV2(8), .DIV3(16), .PULSE(PULSE)) dut (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .bus_addr_in(bus_addr_in),
        .bus_wdata_in(bus_wdata_in),
        .bus_wr_in(bus_wr_in),
        .bus_rd_in(bus_rd_in),
        .bus_rdata_out(bus_rdata_out),
        .int_ack_in(int_ack_in),
        .underflow_interrupt_flag_out(flag),
        .irq_out(irq),
        .chip_reset_out(chip_rst),
        .reset_cause_flag_out(cause)
    );

    // Free-running 125 MHz clock.
    initial begin
        forever #4 ref_clk_in = ~ref_clk_in;
    end

    // =================================================================
    // Helpers. Every wait is bounded so a dead design cannot hang the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge ref_clk_in);
        bus_addr_in <= a;
        bus_wdata_in <= dat;
        bus_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        bus_wr_in <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so it is taken there.
    task automatic rd(input logic [7:0] a, output logic [7:0] dat);
        @(posedge ref_clk_in);
        bus_addr_in <= a;
        bus_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        bus_rd_in <= 1'b0;
        #1;
        dat = bus_rdata_out;
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] got;
        rd(a, got);
        check(name, exp, got);
    endtask

    // Which 0 waits for the interrupt flag, 1 for the chip reset request.
    task automatic wait_high(input int which, input int bound, output int n);
        n = 0;
        while (((which == 0) ? flag : chip_rst) !== 1'b1 && n < bound) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        if (((which == 0) ? flag : chip_rst) !== 1'b1) begin
            failures++;
            $display("wrong value wait expected 1 seen 0");
            conclude();
        end
    endtask

    task automatic pin_reset();
        @(posedge ref_clk_in);
        sys_rst_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
    endtask

    // =================================================================
    // Main sequence.
    initial begin
        repeat (4) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        #1;
        check("reset outputs", 8'h00, {5'h00, flag, irq, chip_rst});
        rdchk("control after pin reset", wdt_pkg::CTRL_OFS, 8'h50);
        rdchk("count after reset", wdt_pkg::COUNT_OFS, 8'hFF);
        rdchk("status after reset", wdt_pkg::STAT_OFS, 8'h00);
        rdchk("mask after reset", wdt_pkg::MASK_OFS, 8'h00);
        wr(8'hA0, 8'h3C);
        rdchk("unmapped read", 8'hA0, 8'h00);
        wr(wdt_pkg::CTRL_OFS, 8'h5C);
        rdchk("read-only control bits", wdt_pkg::CTRL_OFS, 8'h50);
        wr(wdt_pkg::COUNT_OFS, 8'h5A);
        rdchk("count write", wdt_pkg::COUNT_OFS, 8'h5A);
        $display("test registers done");

        // Each select code: underflow after (count+1) periods less under one period.
        for (int s = 0; s < 4; s++) begin
            d = DIV_TAB[s];
            wr(wdt_pkg::COUNT_OFS, 8'h02);
            wr(wdt_pkg::CTRL_OFS, {6'b100100, s[1:0]});
            wait_high(0, 1000, cyc);
            check("underflow interval", 8'h01, {7'h00, cyc >= 2 * d + 1 && cyc <= 3 * d + 2});
            check("interval mode no reset", 8'h00, {7'h00, chip_rst});
            wr(wdt_pkg::CTRL_OFS, 8'h50);
            wr(wdt_pkg::STAT_OFS, 8'h01);
        end
        $display("test clock select done");

        // Run codes 00, 10 and 11 all count; only 01 freezes the counter.
        for (int r = 0; r < 4; r++) begin
            if (r != 1) begin
                wr(wdt_pkg::COUNT_OFS, 8'h80);
                wr(wdt_pkg::CTRL_OFS, {r[1:0], 6'b010000});
                repeat (30) @(posedge ref_clk_in);
                wr(wdt_pkg::CTRL_OFS, 8'h50);
                rd(wdt_pkg::COUNT_OFS, v);
                check("count moved", 8'h01, {7'h00, v < 8'h7A && v > 8'h70});
                repeat (20) @(posedge ref_clk_in);
                rdchk("count frozen", wdt_pkg::COUNT_OFS, v);
            end
        end
        $display("test run pair done");

        // Interval timer with interrupt: mask, acknowledge and write-one-clear.
        wr(wdt_pkg::COUNT_OFS, 8'h00);
        wr(wdt_pkg::CTRL_OFS, 8'h93);
        wait_high(0, 100, cyc);
        check("masked irq", 8'h00, {7'h00, irq});
        check("no reset when disabled", 8'h00, {7'h00, chip_rst});
        rdchk("count wrapped", wdt_pkg::COUNT_OFS, 8'hFF);
        rdchk("status flag", wdt_pkg::STAT_OFS, 8'h01);
        wr(wdt_pkg::MASK_OFS, 8'h01);
        #1;
        check("unmasked irq", 8'h01, {7'h00, irq});
        @(posedge ref_clk_in);
        int_ack_in <= 1'b1;
        @(posedge ref_clk_in);
        int_ack_in <= 1'b0;
        #1;
        check("flag after ack", 8'h00, {6'h00, flag, irq});
        wait_high(0, 5000, cyc);
        wr(wdt_pkg::STAT_OFS, 8'h01);
        #1;
        check("flag after clear", 8'h00, {7'h00, flag});
        rdchk("mask readback", wdt_pkg::MASK_OFS, 8'h01);
        wr(wdt_pkg::CTRL_OFS, 8'h50);
        $display("test interrupt done");

        // Regular reloads with reset enabled keep the chip out of reset.
        wr(wdt_pkg::CTRL_OFS, 8'hA0);
        for (int i = 0; i < 20; i++) begin
            wr(wdt_pkg::COUNT_OFS, 8'h05);
            repeat (8) @(posedge ref_clk_in);
        end
        rd(wdt_pkg::COUNT_OFS, v);
        check("count still running", 8'h01, {7'h00, v < 8'h05});
        check("no underflow on reload", 8'h00, {6'h00, flag, cause});
        wr(wdt_pkg::CTRL_OFS, 8'h50);
        $display("test reload done");

        // Reset-enable codes 00, 10 and 11 all reset the chip on underflow.
        for (int e = 0; e < 4; e++) begin
            if (e != 1) begin
                wr(wdt_pkg::MASK_OFS, 8'h01);
                wr(wdt_pkg::COUNT_OFS, 8'h00);
                wr(wdt_pkg::CTRL_OFS, {2'b10, e[1:0], 4'h1});
                wait_high(1, 100, cyc);
                cyc = 0;
                while (chip_rst === 1'b1 && cyc < 20) begin
                    @(posedge ref_clk_in);
                    #1;
                    cyc++;
                end
                check("reset pulse length", PULSE[7:0], cyc[7:0]);
                check("cause after watchdog reset", 8'h01, {7'h00, cause});
                rdchk("control reinitialised", wdt_pkg::CTRL_OFS, 8'h58);
                rdchk("count reinitialised", wdt_pkg::COUNT_OFS, 8'hFF);
                rdchk("mask reinitialised", wdt_pkg::MASK_OFS, 8'h00);
                rdchk("status reinitialised", wdt_pkg::STAT_OFS, 8'h00);
            end
        end
        $display("test watchdog reset done");

        pin_reset();
        #1;
        check("cause after pin reset", 8'h00, {7'h00, cause});
        rdchk("control after second pin reset", wdt_pkg::CTRL_OFS, 8'h50);
        rdchk("count after pin reset", wdt_pkg::COUNT_OFS, 8'hFF);
        repeat (20) @(posedge ref_clk_in);
        rdchk("stopped after pin reset", wdt_pkg::COUNT_OFS, 8'hFF);
        $display("test pin reset done");
        conclude();
    end
endmodule
`default_nettype wire
